// [cbu_pkg.sv]
package cbu_pkg;

  localparam int PC_W = 16;
  localparam int OFS_W = 7;

  // Status register bit positions
  localparam int SREG_C = 0;
  localparam int SREG_N = 2;
  localparam int SREG_V = 3;
  localparam int SREG_H = 5;
  localparam int SREG_T = 6;

  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYC_TAKEN = 2'h2;

  typedef enum logic [3:0] {
    branch_same_or_higher,
    branch_lower,
    branch_minus,
    branch_plus,
    branch_greater_equal_signed,
    branch_less_than_signed,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_transfer_bit_set
  } cbu_op_type;

  typedef struct packed {
    logic valid;
    cbu_op_type op;
    logic [OFS_W-1:0] offset;
  } cbu_req_type;

  typedef struct packed {
    logic load;
    logic [PC_W-1:0] target;
    logic taken;
    logic busy;
  } cbu_rsp_type;

endpackage

// [cbu_cond.sv]
`timescale 1ns/1ps
module cbu_cond (
  input wire cbu_pkg::cbu_op_type op,
  input wire logic [7:0] sreg,
  output logic hit
);

  always_comb
  begin
    unique case (op)
      cbu_pkg::branch_same_or_higher: hit = ~sreg[cbu_pkg::SREG_C];
      cbu_pkg::branch_lower: hit = sreg[cbu_pkg::SREG_C];
      cbu_pkg::branch_minus: hit = sreg[cbu_pkg::SREG_N];
      cbu_pkg::branch_plus: hit = ~sreg[cbu_pkg::SREG_N];
      cbu_pkg::branch_greater_equal_signed: hit = ~(sreg[cbu_pkg::SREG_N] ^ sreg[cbu_pkg::SREG_V]);
      cbu_pkg::branch_less_than_signed: hit = sreg[cbu_pkg::SREG_N] ^ sreg[cbu_pkg::SREG_V];
      cbu_pkg::branch_half_carry_set: hit = sreg[cbu_pkg::SREG_H];
      cbu_pkg::branch_half_carry_clear: hit = ~sreg[cbu_pkg::SREG_H];
      cbu_pkg::branch_transfer_bit_set: hit = sreg[cbu_pkg::SREG_T];
      default: hit = 1'b0;
    endcase
  end

endmodule

// [cbu_branch_unit.sv]
// Function
// - Same-or-higher branch taken only when carry is clear.
// - Lower branch taken only when carry is set.
// - Minus branch taken only when negative flag is one.
// - Plus branch taken only when negative flag is zero.
// - Signed greater-or-equal taken only when negative xor overflow is zero.
// - Signed less-than taken only when negative xor overflow is one.
// - Half-carry-set branch taken only when half carry is one.
// - Half-carry-clear branch taken only when half carry is zero.
// - Transfer-bit-set branch taken only when transfer bit is one.
// - Taken loads PC+offset+1; one cycle not taken, two taken; flags untouched.
`timescale 1ns/1ps
module cbu_branch_unit (
  input wire logic core_clk,
  input wire logic rst,
  input cbu_pkg::cbu_req_type req,
  input wire logic [cbu_pkg::PC_W-1:0] pc,
  input wire logic [7:0] sreg,
  output cbu_pkg::cbu_rsp_type rsp,
  output logic [7:0] sreg_out,
  output logic [1:0] cycles
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SECOND
  } cbu_state_type;

  typedef struct packed {
    cbu_state_type st;
    cbu_pkg::cbu_rsp_type rsp;
    logic [1:0] cycles;
    logic [7:0] flags;
  } cbu_regs_type;

  cbu_regs_type state_reg;
  cbu_regs_type state_next;
  logic hit;
  logic [cbu_pkg::PC_W-1:0] ofs_ext;

  cbu_cond u_cond (
    .op(req.op),
    .sreg(sreg),
    .hit(hit)
  );

  assign ofs_ext = {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){req.offset[cbu_pkg::OFS_W-1]}}, req.offset};
  assign sreg_out = state_reg.flags;

  always_comb
  begin
    state_next = state_reg;
    state_next.rsp.load = 1'b0;
    state_next.flags = sreg;
    unique case (state_reg.st)
      ST_IDLE:
      begin
        state_next.rsp.busy = 1'b0;
        if (req.valid)
        begin
          state_next.rsp.taken = hit;
          if (hit)
          begin
            state_next.rsp.target = pc + ofs_ext + cbu_pkg::PC_STEP;
            state_next.rsp.busy = 1'b1;
            state_next.cycles = cbu_pkg::CYC_TAKEN;
            state_next.st = ST_SECOND;
          end
          else
          begin
            state_next.cycles = cbu_pkg::CYC_NOT_TAKEN;
          end
        end
      end
      ST_SECOND:
      begin
        state_next.rsp.load = 1'b1;
        state_next.rsp.busy = 1'b0;
        state_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '{st: ST_IDLE, rsp: '{load: 1'b0, target: cbu_pkg::PC_RESET, taken: 1'b0, busy: 1'b0},
                     cycles: 2'h0, flags: 8'h00};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rsp = state_reg.rsp;
  assign cycles = state_reg.cycles;

  sequence s_taken_req;
    req.valid && !state_reg.rsp.busy && hit;
  endsequence

  sequence s_load_after;
    ##2 rsp.load;
  endsequence

  AST_LOAD_TWO: assert property (@(posedge core_clk) disable iff (rst) s_taken_req |-> s_load_after)
    else $error("taken branch did not load on second cycle");
  sequence s_accept;
    req.valid && !rsp.busy;
  endsequence

  sequence s_not_taken_req;
    req.valid && !rsp.busy && !hit;
  endsequence

  sequence s_refused_req;
    req.valid && rsp.busy;
  endsequence

  sequence s_no_accept;
    !(req.valid && !rsp.busy);
  endsequence

  // Busy for one cycle, then a single load pulse
  sequence s_busy_then_load;
    ##1 rsp.busy && !rsp.load ##1 !rsp.busy && rsp.load ##1 !rsp.load;
  endsequence

  AST_TARGET: assert property (@(posedge core_clk) disable iff (rst)
    s_taken_req
    |=> rsp.target == $past(pc) + {{9{$past(req.offset[6])}}, $past(req.offset)} + 16'h0001)
    else $error("branch target wrong");
  AST_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (rst)
    s_not_taken_req
    |=> !rsp.busy ##1 !rsp.load)
    else $error("not-taken branch took extra cycle");
  AST_CARRY_CLR: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_same_or_higher
    |=> rsp.taken == !$past(sreg[cbu_pkg::SREG_C]))
    else $error("same-or-higher decision wrong");
  AST_CARRY_SET: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_lower
    |=> rsp.taken == $past(sreg[cbu_pkg::SREG_C]))
    else $error("lower decision wrong");
  AST_MINUS: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_minus
    |=> rsp.taken == $past(sreg[cbu_pkg::SREG_N]))
    else $error("minus decision wrong");
  AST_PLUS: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_plus
    |=> rsp.taken == !$past(sreg[cbu_pkg::SREG_N]))
    else $error("plus decision wrong");
  AST_GE: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_greater_equal_signed
    |=> rsp.taken == !($past(sreg[cbu_pkg::SREG_N]) ^ $past(sreg[cbu_pkg::SREG_V])))
    else $error("signed ge decision wrong");
  AST_LT: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_less_than_signed
    |=> rsp.taken == ($past(sreg[cbu_pkg::SREG_N]) ^ $past(sreg[cbu_pkg::SREG_V])))
    else $error("signed lt decision wrong");
  AST_HS: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_half_carry_set
    |=> rsp.taken == $past(sreg[cbu_pkg::SREG_H]))
    else $error("half carry set decision wrong");
  AST_HC: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_half_carry_clear
    |=> rsp.taken == !$past(sreg[cbu_pkg::SREG_H]))
    else $error("half carry clear decision wrong");
  AST_TS: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && req.op == cbu_pkg::branch_transfer_bit_set
    |=> rsp.taken == $past(sreg[cbu_pkg::SREG_T]))
    else $error("transfer bit decision wrong");

  AST_BUSY_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    s_taken_req
    |-> s_busy_then_load)
    else $error("taken branch busy and load order wrong");
  AST_CYC_TAKEN: assert property (@(posedge core_clk) disable iff (rst)
    s_taken_req
    |=> cycles == cbu_pkg::CYC_TAKEN && rsp.taken)
    else $error("taken branch cycle count wrong");
  AST_CYC_NOT_TAKEN: assert property (@(posedge core_clk) disable iff (rst)
    s_not_taken_req
    |=> cycles == cbu_pkg::CYC_NOT_TAKEN && !rsp.taken)
    else $error("not-taken branch cycle count wrong");
  AST_REFUSED: assert property (@(posedge core_clk) disable iff (rst)
    s_refused_req
    |=> rsp.target == $past(rsp.target) && rsp.taken == $past(rsp.taken) && cycles == $past(cycles) && !rsp.busy)
    else $error("request during busy cycle was taken");
  AST_TARGET_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    s_no_accept
    |=> rsp.target == $past(rsp.target))
    else $error("target changed without a request");
  AST_TARGET_NT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    s_not_taken_req
    |=> rsp.target == $past(rsp.target))
    else $error("target changed on not-taken branch");
  AST_DECIDE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    s_no_accept
    |=> rsp.taken == $past(rsp.taken) && cycles == $past(cycles))
    else $error("decision changed without a request");

  AST_LOAD_AFTER_BUSY: assert property (@(posedge core_clk) disable iff (rst)
    rsp.load
    |-> $past(rsp.busy))
    else $error("load pulse without busy cycle");
  AST_LOAD_ONE: assert property (@(posedge core_clk) disable iff (rst)
    rsp.load
    |=> !rsp.load)
    else $error("load pulse longer than one cycle");
  AST_BUSY_ONE: assert property (@(posedge core_clk) disable iff (rst)
    rsp.busy
    |=> !rsp.busy)
    else $error("busy longer than one cycle");
  AST_FLAGS_KEPT: assert property (@(posedge core_clk) disable iff (rst)
    s_accept
    |=> sreg_out == $past(sreg))
    else $error("status flags altered by branch");

  AST_OFS_BACK: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && hit && req.offset[cbu_pkg::OFS_W-1]
    |=> rsp.target == $past(pc) + 16'h0001 - {9'h000, 7'h00 - $past(req.offset)})
    else $error("backward branch target wrong");
  AST_OFS_FWD: assert property (@(posedge core_clk) disable iff (rst)
    req.valid && !rsp.busy && hit && !req.offset[cbu_pkg::OFS_W-1]
    |=> rsp.target == $past(pc) + {9'h000, $past(req.offset)} + 16'h0001)
    else $error("forward branch target wrong");

endmodule

// [cbu_branch_unit_tb_top.sv]
`timescale 1ns/1ps
module cbu_branch_unit_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  cbu_pkg::cbu_req_type req = '0;
  logic [15:0] pc = 16'h0000;
  logic [7:0] sreg = 8'h00;
  cbu_pkg::cbu_rsp_type rsp;
  logic [7:0] sreg_out;
  logic [1:0] cycles;
  int fail_count = 0;
  int n_checks = 0;
  int ticks = 0;
  always #2 core_clk = ~core_clk;
  cbu_branch_unit i_cbu_branch_unit (.core_clk(core_clk), .rst(rst), .req(req), .pc(pc), .sreg(sreg),
    .rsp(rsp), .sreg_out(sreg_out), .cycles(cycles));
  function automatic logic hit(input int op, input logic [7:0] s);
    case (op)
      0: return !s[0];
      1: return s[0];
      2: return s[2];
      3: return !s[2];
      4: return !(s[2] ^ s[3]);
      5: return s[2] ^ s[3];
      6: return s[5];
      7: return !s[5];
      default: return s[6];
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One request, then the decision, timing and target
  task automatic br(input int op, input logic [7:0] s, input logic [6:0] k, input logic [15:0] p);
    logic t;
    t = hit(op, s);
    @(posedge core_clk);
    req <= '{1'b1, cbu_pkg::cbu_op_type'(op[3:0]), k};
    sreg <= s;
    pc <= p;
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    chk(rsp.taken, t, "decision");
    chk(cycles, t ? 2'h2 : 2'h1, "cycle count");
    chk(rsp.busy, t, "busy");
    chk(sreg_out, s, "flags altered");
    if (t)
    begin
      @(posedge core_clk);
      #1;
      chk(rsp.load, 1'b1, "load pulse");
      chk(rsp.target, p + {{9{k[6]}}, k} + 16'h0001, "target");
    end
    else
    begin
      @(posedge core_clk);
      #1;
      chk(rsp.load, 1'b0, "stray load");
      chk(rsp.busy, 1'b0, "stray busy");
    end
  endtask
  task automatic t_conditions;
    logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
    for (int i = 0; i < 9; i++)
      for (int j = 0; j < 4; j++)
        br(i, pat[j], 7'h05, 16'h0010);
    $display("conditions done");
  endtask
  task automatic t_offsets;
    br(8, 8'h40, 7'h40, 16'h0000);
    br(8, 8'h40, 7'h3F, 16'hFFF0);
    br(0, 8'h00, 7'h7F, 16'h1234);
    $display("offsets done");
  endtask
  // A request during the busy cycle must leave no trace
  task automatic t_refused;
    @(posedge core_clk);
    req <= '{1'b1, cbu_pkg::branch_transfer_bit_set, 7'h05};
    sreg <= 8'h40;
    pc <= 16'h0100;
    @(posedge core_clk);
    req.offset <= 7'h10;
    pc <= 16'h0200;
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    chk(rsp.load, 1'b1, "load pulse");
    chk(rsp.target, 16'h0106, "busy request taken");
    @(posedge core_clk);
    #1;
    chk(rsp.load, 1'b0, "second load");
    $display("refusal done");
  endtask
  always @(posedge core_clk)
  begin
    ticks++;
    if (ticks == 2000)
    begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_conditions();
    t_offsets();
    t_refused();
    wrap_up();
  end
endmodule
